//--- include/dnc_defines.svh
// Purpose: Offsets, reset values and field positions of the oscillator control registers
// Assumes: Byte-wide registers at word indices 13..15
// Notes: Definitions only
`ifndef DNC_DEFINES_SVH
`define DNC_DEFINES_SVH
`define DNC_ADDR_OSC_CTRL 4'h0d
`define DNC_ADDR_TEST_TIMING 4'h0e
`define DNC_ADDR_UPDATE 4'h0f
`define DNC_OSC_CTRL_RST 8'hf8
`define DNC_TEST_TIMING_RST 8'h10
`define DNC_OSC_SER_EN_BIT 6
`define DNC_OSC_ACC_EN_BIT 5
`define DNC_TT_SETUP_LO 4
`define DNC_TT_SETUP_HI 5
`define DNC_TT_SETUP_RST 2'b01
`endif

//--- include/dnc_pkg.sv
// Purpose: Types shared by the oscillator control register bank
// Assumes: Nothing beyond the defines header
// Notes: Carrier struct for the active (slave) control values
package dnc_pkg;
	typedef struct packed
	{
		logic serFreqEn;
		logic accFeedbackEn;
		logic [1:0] setupHold;
		logic [7:0] oscCtrl;
		logic [7:0] testTiming;
	} dnc_active_s;
endpackage

//--- logic/dnc_control_regs.sv
// Purpose: Master/slave control registers at indices 13..15 with update strobe
// Assumes: Plain write/read strobe port on ref_clk; update pin already synchronous
// Notes: Slave values steer the datapath; masters are what software reads back
//
// Contract
// - Osc control bit 6 gates the serial word onto the accumulator input; reset one.
// - Clearing that enable only gates the path and leaves the stored serial word untouched.
// - Osc control bit 5 high enables accumulator feedback, low stops accumulation; reset one.
// - Test and timing bits 5:4 set oscillator-to-converter timing, only 11b or 00b are legal; the code resets them to 01b and flags 01b/10b on timingInvalid.
// - Any write to index 15 is an update strobe equal to the external update pin.
// - Index 15 holds no storage and reads back zero.
//
// The strobed register port is this design's own decision.
`include "dnc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dnc_control_regs
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	// Update pin, active low, from same clock domain
	input wire logic updateIn_n,
	// Datapath gating
	input wire logic [39:0] serFreqWord,
	output logic [39:0] serFreqToAcc,
	output logic accFeedbackEn,
	output logic [1:0] setupHold,
	output logic updatePulse,
	output logic timingInvalid
);
	// ==========================================================
	// Register state
	logic [7:0] oscMaster_reg, oscMaster_next;
	logic [7:0] ttMaster_reg, ttMaster_next;
	dnc_pkg::dnc_active_s active_reg, active_next;
	logic [7:0] regRdData_reg, regRdData_next;
	logic [39:0] serOut_reg, serOut_next;
	logic updPulse_reg, updPulse_next;
	logic timingInv_reg, timingInv_next;
	logic doUpdate;
	logic wrOsc;
	logic wrTiming;
	logic wrUpdate;
	// ==========================================================
	// Decode helpers
	// True when a write strobe targets the given index
	function automatic logic wrHit(input logic stb, input logic [3:0] addr,
		input logic [3:0] target);
		return stb && (addr == target);
	endfunction
	// Setup/hold codes with mixed bits are not usable operating settings
	function automatic logic badTiming(input logic [1:0] code);
		return (code == 2'b01) || (code == 2'b10);
	endfunction
	// ==========================================================
	// Address decode
	assign wrOsc = wrHit(regWrStb, regAddr, `DNC_ADDR_OSC_CTRL);
	assign wrTiming = wrHit(regWrStb, regAddr, `DNC_ADDR_TEST_TIMING);
	// Index 15 decodes to a strobe only; there is no flop behind it
	assign wrUpdate = wrHit(regWrStb, regAddr, `DNC_ADDR_UPDATE);
	// Pin is a level: every low cycle repeats the copy
	assign doUpdate = wrUpdate || !updateIn_n;
	// ==========================================================
	// Master registers
	always_comb
	begin
		oscMaster_next = oscMaster_reg;
		ttMaster_next = ttMaster_reg;
		if (wrOsc)
		begin
			// Reserved bits stored as written; keeping them is software's duty
			oscMaster_next = regWrData;
		end
		if (wrTiming)
		begin
			// Any code is stored; a bad code is flagged once it is active
			ttMaster_next = regWrData;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			oscMaster_reg <= `DNC_OSC_CTRL_RST;
			ttMaster_reg <= `DNC_TEST_TIMING_RST;
		end
		else
		begin
			oscMaster_reg <= oscMaster_next;
			ttMaster_reg <= ttMaster_next;
		end
	end
	// ==========================================================
	// Slave registers
	always_comb
	begin
		active_next = active_reg;
		if (doUpdate)
		begin
			// Uses pre-write masters; a same-cycle write lands on the next update
			active_next.oscCtrl = oscMaster_reg;
			active_next.testTiming = ttMaster_reg;
			active_next.serFreqEn = oscMaster_reg[`DNC_OSC_SER_EN_BIT];
			active_next.accFeedbackEn = oscMaster_reg[`DNC_OSC_ACC_EN_BIT];
			active_next.setupHold = ttMaster_reg[`DNC_TT_SETUP_HI:`DNC_TT_SETUP_LO];
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			active_reg <= '{serFreqEn: 1'b1, accFeedbackEn: 1'b1,
				setupHold: `DNC_TT_SETUP_RST,
				oscCtrl: `DNC_OSC_CTRL_RST, testTiming: `DNC_TEST_TIMING_RST};
		end
		else
		begin
			active_reg <= active_next;
		end
	end
	// ==========================================================
	// Read-back
	always_comb
	begin
		regRdData_next = 8'h00;
		if (regRdStb)
		begin
			unique case (regAddr)
				`DNC_ADDR_OSC_CTRL: regRdData_next = oscMaster_reg;
				`DNC_ADDR_TEST_TIMING: regRdData_next = ttMaster_reg;
				default: regRdData_next = 8'h00;
			endcase
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			regRdData_reg <= 8'h00;
		end
		else
		begin
			regRdData_reg <= regRdData_next;
		end
	end
	// ==========================================================
	// Serial frequency path
	always_comb
	begin
		// Gate only the path; serFreqWord itself is never touched
		serOut_next = active_reg.serFreqEn ? serFreqWord : 40'h00_0000_0000;
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			serOut_reg <= 40'h00_0000_0000;
		end
		else
		begin
			serOut_reg <= serOut_next;
		end
	end
	// ==========================================================
	// Update pulse
	always_comb
	begin
		updPulse_next = doUpdate;
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			updPulse_reg <= 1'b0;
		end
		else
		begin
			updPulse_reg <= updPulse_next;
		end
	end
	// ==========================================================
	// Timing flag
	always_comb
	begin
		// Follows the slave value so the flag and setupHold change together
		timingInv_next = badTiming(active_next.setupHold);
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			// Reset code 01b is not an operating setting
			timingInv_reg <= 1'b1;
		end
		else
		begin
			timingInv_reg <= timingInv_next;
		end
	end
	// ==========================================================
	// Outputs
	assign regRdData = regRdData_reg;
	assign serFreqToAcc = serOut_reg;
	assign accFeedbackEn = active_reg.accFeedbackEn;
	assign setupHold = active_reg.setupHold;
	assign updatePulse = updPulse_reg;
	assign timingInvalid = timingInv_reg;
endmodule
`default_nettype wire

//--- testbench/dnc_control_regs_properties.sv
// Purpose: port checks. Assumes: one clock, srst. Notes: bound by the bench
`timescale 1ns/100ps
`default_nettype none
module dnc_control_regs_properties
(
	input wire logic ref_clk, srst, regWrStb, regRdStb, updateIn_n,
	input wire logic accFeedbackEn, updatePulse, timingInvalid,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regRdData,
	input wire logic [39:0] serFreqWord, serFreqToAcc,
	input wire logic [1:0] setupHold
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire logic updReq = !updateIn_n || (regWrStb && regAddr == 4'hf);
	sequence s_upd; updReq ##1 updatePulse; endsequence
	chk_upd_now: assert property (updReq |-> s_upd) else $error("no update");
	chk_upd_cause: assert property (updatePulse |-> $past(updReq)) else $error("stray");
	chk_acc_hold: assert property ($changed(accFeedbackEn) |-> updatePulse) else $error("acc");
	chk_sh_hold: assert property ($changed(setupHold) |-> updatePulse) else $error("sh");
	chk_ser_path: assert property (serFreqToAcc != 0 |->
		serFreqToAcc == $past(serFreqWord)) else $error("path");
	chk_upd_noread: assert property (regRdStb && regAddr == 4'hf |=> !regRdData)
		else $error("read");
	chk_timing_flag: assert property (timingInvalid == (setupHold == 2'b01 || setupHold == 2'b10))
		else $error("flag");
endmodule
`default_nettype wire

//--- testbench/dnc_host_model.sv
// Purpose: host master. Assumes: one-cycle strobes. Notes: tasks used by the bench
`timescale 1ns/100ps
`default_nettype none
module dnc_host_model
(
	input wire logic ref_clk,
	output logic [3:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrStb, regRdStb, updateIn_n
);
	initial {regAddr, regWrData, regWrStb, regRdStb, updateIn_n} = 15'h0001;
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		{regAddr, regWrData, regWrStb, regRdStb} <= {a, d, w, !w};
		@(posedge ref_clk);
		{regWrStb, regRdStb} <= 2'b00;
	endtask
	task automatic pin;
		@(posedge ref_clk);
		updateIn_n <= 0;
		@(posedge ref_clk);
		updateIn_n <= 1;
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_dnc_control_regs.sv
// Purpose: bench. Assumes: 125 MHz. Notes: fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_dnc_control_regs;
	logic ref_clk = 0, srst = 1, regWrStb, regRdStb, updateIn_n;
	logic accFeedbackEn, updatePulse, timingInvalid;
	logic [39:0] serFreqWord = 0, serFreqToAcc;
	logic [7:0] regRdData, regWrData;
	logic [3:0] regAddr;
	logic [1:0] setupHold;
	int fails = 0, comparisons = 0;
	dnc_host_model u_host (.ref_clk, .regAddr, .regWrData, .regWrStb, .regRdStb, .updateIn_n);
	dnc_control_regs u_dut (.ref_clk, .srst, .regAddr, .regWrData, .regWrStb, .regRdStb,
		.regRdData, .updateIn_n, .serFreqWord, .serFreqToAcc, .accFeedbackEn, .setupHold,
		.updatePulse, .timingInvalid);
	function automatic logic [39:0] expSer(input logic [7:0] c);
		return c[6] ? serFreqWord : 40'h0;
	endfunction
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		u_host.acc(0, a, 8'h00);
		#1 `CHK(regRdData, e)
	endtask
	task automatic check(input logic [7:0] c, input logic [7:0] t);
		repeat (2) @(posedge ref_clk);
		#1 `CHK(accFeedbackEn, c[5])
		`CHK(setupHold, t[5:4])
		`CHK(timingInvalid, t[5:4] == 2'b01 || t[5:4] == 2'b10)
		`CHK(serFreqToAcc, expSer(c))
	endtask
	task end_sim;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial forever #4 ref_clk = ~ref_clk;
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		fails++;
		end_sim;
	end
	initial
	begin
		logic [7:0] c;
		logic [7:0] t;
		void'($urandom(65807));
		serFreqWord = 40'({$urandom, $urandom});
		repeat (5) @(posedge ref_clk);
		srst <= 0;
		rd(4'hd, 8'hf8);
		rd(4'he, 8'h10);
		check(8'hf8, 8'h10);
		u_host.acc(1, 4'hd, 8'hb8);
		u_host.acc(1, 4'he, 8'h30);
		check(8'hf8, 8'h10);
		u_host.acc(1, 4'hf, 8'($urandom));
		check(8'hb8, 8'h30);
		rd(4'hf, 8'h00);
		u_host.acc(1, 4'hd, 8'hd8);
		u_host.acc(1, 4'he, 8'h00);
		u_host.pin;
		check(8'hd8, 8'h00);
		repeat (8)
		begin
			c = {1'b1, 2'($urandom), 5'b1_1000};
			t = $urandom_range(1) ? 8'h30 : 8'h00;
			u_host.acc(1, 4'hd, c);
			u_host.acc(1, 4'he, t);
			u_host.acc(1, 4'hf, 8'($urandom));
			check(c, t);
			rd(4'hd, c);
		end
		@(posedge ref_clk);
		srst <= 1;
		repeat (5) @(posedge ref_clk);
		srst <= 0;
		rd(4'he, 8'h10);
		check(8'hf8, 8'h10);
		end_sim;
	end
endmodule
bind dnc_control_regs dnc_control_regs_properties u_chk (.ref_clk, .srst, .regWrStb,
	.regRdStb, .updateIn_n, .accFeedbackEn, .updatePulse, .timingInvalid, .regAddr,
	.regRdData, .serFreqWord, .serFreqToAcc, .setupHold);
`default_nettype wire
